// *** design/pio_top.sv ***
`timescale 1ns/1ps
`include "pio_defines.svh"
module pio_top import pio_pkg::*; #(
  parameter int AW = 12
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic [AW-1:0] awaddr,
  input  wire logic          awvalid,
  output logic               awready,
  input  wire logic [31:0]   wdata,
  input  wire logic [3:0]    wstrb,
  input  wire logic          wvalid,
  output logic               wready,
  output logic [1:0]         bresp,
  output logic               bvalid,
  input  wire logic          bready,
  input  wire logic [AW-1:0] araddr,
  input  wire logic          arvalid,
  output logic               arready,
  output logic [31:0]        rdata,
  output logic [1:0]         rresp,
  output logic               rvalid,
  input  wire logic          rready,
  input  wire logic [7:0]    pin_b_i,
  input  wire logic [7:0]    pin_c_i,
  input  wire logic [7:0]    pin_d_i,
  output pio_pad_t           pad_b,
  output pio_pad_t           pad_c,
  output pio_pad_t           pad_d,
  input  wire logic [7:0]    ext_irq_ack,
  input  wire logic [1:0]    change_irq_ack,
  output pio_irq_t           irq_req,
  output logic               irq,
  output logic               wake
);
  logic [23:0]   s1, s2, s3, filt, filt_old;
  logic [7:0]    ext_in, trig, lvl, lvl_mode, ext_set, ext_clr;
  logic [3:0]    ext_old;
  logic [7:4]    samp_now, samp_old;
  logic [12:0]   chg_in, chg_old, chg_diff;
  logic [15:0]   sense;
  logic [9:0]    irq_ev;
  logic          grp_lo, grp_hi, io_run, io_tick, wake_ev;
  logic          aw_got, w_got, do_write, wr, wstrb_q;
  logic [AW-1:0] aw_addr;
  logic [7:0]    w_data, wix;
  logic [8:0]    rd_ar, rd_aw;
  logic [7:0]    lat_b, lat_c, lat_d, dir_b, dir_c, dir_d, core_ctl;
  logic [7:0]    sns_lo, sns_hi, ext_en, ext_flag, msk_lo;
  logic [4:0]    msk_hi;
  logic [1:0]    chg_en, chg_flag, slp;
  logic [9:0]    irq_st, irq_en;

  // ****************************************
  // address decode
  // ****************************************
  function automatic logic [8:0] rd_val(input logic [AW-1:0] a);
    logic [7:0] ix;
    ix = a[9:2];
    rd_val = 9'h000;
    if (a[AW-1:10] != '0) rd_val = 9'h000;
    else if (ix == `PIO_IX_PIN_B) rd_val = {1'b1, filt[7:0]};
    else if (ix == `PIO_IX_DIR_B) rd_val = {1'b1, dir_b};
    else if (ix == `PIO_IX_LAT_B) rd_val = {1'b1, lat_b};
    else if (ix == `PIO_IX_PIN_C) rd_val = {1'b1, filt[15:8] & `PIO_PORT_C_OUTPUT_LATCH_MASK};
    else if (ix == `PIO_IX_DIR_C) rd_val = {1'b1, dir_c};
    else if (ix == `PIO_IX_LAT_C) rd_val = {1'b1, lat_c};
    else if (ix == `PIO_IX_PIN_D) rd_val = {1'b1, filt[23:16]};
    else if (ix == `PIO_IX_DIR_D) rd_val = {1'b1, dir_d};
    else if (ix == `PIO_IX_LAT_D) rd_val = {1'b1, lat_d};
    else if (ix == `PIO_IX_CORE) rd_val = {1'b1, core_ctl};
    else if (ix == `PIO_IX_SNS_LO) rd_val = {1'b1, sns_lo};
    else if (ix == `PIO_IX_SNS_HI) rd_val = {1'b1, sns_hi};
    else if (ix == `PIO_IX_EXT_EN) rd_val = {1'b1, ext_en};
    else if (ix == `PIO_IX_EXT_FLG) rd_val = {1'b1, ext_flag};
    else if (ix == `PIO_IX_CHG_EN) rd_val = {1'b1, 6'h00, chg_en};
    else if (ix == `PIO_IX_CHG_FLG) rd_val = {1'b1, 6'h00, chg_flag};
    else if (ix == `PIO_IX_MSK_LO) rd_val = {1'b1, msk_lo};
    else if (ix == `PIO_IX_MSK_HI) rd_val = {1'b1, 3'h0, msk_hi};
    else if (ix == `PIO_IX_SLEEP) rd_val = {1'b1, 6'h00, slp};
    else if (ix == `PIO_IX_IRQ_ST) rd_val = {1'b1, irq_st[7:0]};
    else if (ix == `PIO_IX_IRQ_CLR) rd_val = 9'h100;
    else if (ix == `PIO_IX_IRQ_EN) rd_val = {1'b1, irq_en[7:0]};
  endfunction
  // group status bits 9:8 are not readable, only cleared through the clear register
  // always_comb follows the registers the function reads, a plain assign would not
  always_comb begin
    rd_ar = rd_val(araddr);
    rd_aw = rd_val(aw_addr);
  end
  assign wix = aw_addr[9:2];
  assign do_write = aw_got & w_got & ~bvalid;
  assign wr = do_write & rd_aw[8] & wstrb_q;

  // ****************************************
  // axi4-lite write channel
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      aw_got <= 1'b0;
      aw_addr <= '0;
    end else if (awvalid && awready) begin
      awready <= 1'b0;
      aw_got <= 1'b1;
      aw_addr <= awaddr;
    end else if (do_write) begin
      aw_got <= 1'b0;
    end else if (!aw_got && !bvalid) begin
      awready <= 1'b1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready <= 1'b0;
      w_got <= 1'b0;
      w_data <= `PIO_RST_BYTE;
      wstrb_q <= 1'b0;
    end else if (wvalid && wready) begin
      wready <= 1'b0;
      w_got <= 1'b1;
      w_data <= wdata[7:0];
      wstrb_q <= wstrb[0];
    end else if (do_write) begin
      w_got <= 1'b0;
    end else if (!w_got && !bvalid) begin
      wready <= 1'b1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= `PIO_RESP_OK;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp <= rd_aw[8] ? `PIO_RESP_OK : `PIO_RESP_ERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // ****************************************
  // axi4-lite read channel
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `PIO_RESP_OK;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= {24'h00_0000, rd_ar[7:0]};
      rresp <= rd_ar[8] ? `PIO_RESP_OK : `PIO_RESP_ERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end else if (!rvalid) begin
      arready <= 1'b1;
    end
  end

  // ****************************************
  // port registers
  // ****************************************
  // writing ones to a pin input register toggles the output latch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lat_b <= `PIO_RST_BYTE;
      lat_c <= `PIO_RST_BYTE;
      lat_d <= `PIO_RST_BYTE;
      dir_b <= `PIO_RST_BYTE;
      dir_c <= `PIO_RST_BYTE;
      dir_d <= `PIO_RST_BYTE;
      core_ctl <= `PIO_RST_BYTE;
    end else if (wr) begin
      if (wix == `PIO_IX_PIN_B) lat_b <= lat_b ^ w_data;
      else if (wix == `PIO_IX_DIR_B) dir_b <= w_data;
      else if (wix == `PIO_IX_LAT_B) lat_b <= w_data;
      else if (wix == `PIO_IX_PIN_C) lat_c <= (lat_c ^ w_data) & `PIO_PORT_C_OUTPUT_LATCH_MASK;
      else if (wix == `PIO_IX_DIR_C) dir_c <= w_data & `PIO_PORT_C_OUTPUT_LATCH_MASK;
      else if (wix == `PIO_IX_LAT_C) lat_c <= w_data & `PIO_PORT_C_OUTPUT_LATCH_MASK;
      else if (wix == `PIO_IX_PIN_D) lat_d <= lat_d ^ w_data;
      else if (wix == `PIO_IX_DIR_D) dir_d <= w_data;
      else if (wix == `PIO_IX_LAT_D) lat_d <= w_data;
      else if (wix == `PIO_IX_CORE) core_ctl <= w_data & `PIO_CORE_MASK;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pad_b <= '0;
      pad_c <= '0;
      pad_d <= '0;
    end else begin
      pad_b <= '{pull: ~dir_b & lat_b & {8{~core_ctl[`PIO_PUD_BIT]}}, oe: dir_b, out: lat_b};
      pad_c <= '{pull: ~dir_c & lat_c & {8{~core_ctl[`PIO_PUD_BIT]}}, oe: dir_c, out: lat_c};
      pad_d <= '{pull: ~dir_d & lat_d & {8{~core_ctl[`PIO_PUD_BIT]}}, oe: dir_d, out: lat_d};
    end
  end

  // ****************************************
  // interrupt control registers
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sns_lo <= `PIO_RST_BYTE;
      sns_hi <= `PIO_RST_BYTE;
      ext_en <= `PIO_RST_BYTE;
      chg_en <= 2'b00;
      msk_lo <= `PIO_RST_BYTE;
      msk_hi <= 5'h00;
      irq_en <= 10'h000;
    end else if (wr) begin
      if (wix == `PIO_IX_SNS_LO) sns_lo <= w_data;
      else if (wix == `PIO_IX_SNS_HI) sns_hi <= w_data;
      else if (wix == `PIO_IX_EXT_EN) ext_en <= w_data;
      else if (wix == `PIO_IX_CHG_EN) chg_en <= w_data[1:0];
      else if (wix == `PIO_IX_MSK_LO) msk_lo <= w_data;
      else if (wix == `PIO_IX_MSK_HI) msk_hi <= w_data[4:0];
      else if (wix == `PIO_IX_IRQ_EN) irq_en <= {chg_en, w_data}; // group enables copy the change enables
    end
  end

  // ****************************************
  // pin synchroniser, three stages with agreement
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1 <= 24'h00_0000;
      s2 <= 24'h00_0000;
      s3 <= 24'h00_0000;
      filt <= 24'h00_0000;
      filt_old <= 24'h00_0000;
    end else begin
      s1 <= {pin_d_i, pin_c_i, pin_b_i};
      s2 <= s1;
      s3 <= s2;
      filt <= ((s2 ~^ s3) & s3) | ((s2 ^ s3) & filt);
      filt_old <= filt;
    end
  end
  // pins are watched on the pad side, so driven outputs count too
  assign ext_in = {filt[23], filt[22], filt[20], filt[15], filt[19:16]};
  assign ext_old = filt_old[19:16];
  assign chg_in = {filt[21], filt[10], filt[14:12], filt[7:0]};
  assign chg_old = {filt_old[21], filt_old[10], filt_old[14:12], filt_old[7:0]};
  assign sense = {sns_hi, sns_lo};

  // ****************************************
  // gated i/o clock domain, as an enable
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      io_run <= 1'b1;
      io_tick <= 1'b0;
      samp_now <= 4'h0;
      samp_old <= 4'h0;
    end else begin
      io_run <= ~(slp[`PIO_SLP_ON] & ~slp[`PIO_SLP_IDLE]);
      io_tick <= io_run;
      if (io_run) begin
        samp_now <= ext_in[7:4];
        samp_old <= samp_now;
      end
    end
  end

  // ****************************************
  // external pin sense logic
  // ****************************************
  for (genvar n = 0; n < 8; n++) begin : g_ext
    logic [1:0] sel;
    logic       cur, old, gate;
    assign sel = sense[2*n+1 -: 2];
    if (n < 4) begin : g_async
      assign cur = ext_in[n];
      assign old = ext_old[n];
      assign gate = 1'b1;
    end else begin : g_sync
      assign cur = samp_now[n];
      assign old = samp_old[n];
      assign gate = io_tick;
    end
    always_comb begin
      case (sel)
        `PIO_SNS_ANY:  trig[n] = cur ^ old;
        `PIO_SNS_FALL: trig[n] = old & ~cur;
        `PIO_SNS_RISE: trig[n] = ~old & cur;
        default:       trig[n] = 1'b0;
      endcase
    end
    assign lvl_mode[n] = (sel == `PIO_SNS_LEVEL);
    assign lvl[n] = lvl_mode[n] & ~ext_in[n];
    assign ext_set[n] = trig[n] & gate;
  end
  assign ext_clr = ((wr && wix == `PIO_IX_EXT_FLG) ? w_data : 8'h00) | ext_irq_ack;

  // set wins over clear; level mode holds the flag at zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_flag <= `PIO_RST_BYTE;
    end else begin
      ext_flag <= (ext_set | (ext_flag & ~ext_clr)) & ~lvl_mode;
    end
  end

  // ****************************************
  // pin change groups
  // ****************************************
  assign chg_diff = chg_in ^ chg_old;
  assign grp_lo = |(chg_diff[7:0] & msk_lo);
  assign grp_hi = |(chg_diff[12:8] & msk_hi);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chg_flag <= 2'b00;
    end else begin
      chg_flag <= {grp_hi, grp_lo} | (chg_flag & ~(change_irq_ack |
                  ((wr && wix == `PIO_IX_CHG_FLG) ? w_data[1:0] : 2'b00)));
    end
  end

  // ****************************************
  // requests, sticky status, sleep and wake
  // ****************************************
  assign irq_ev = {grp_hi, grp_lo, ext_set | lvl};
  assign wake_ev = grp_lo | grp_hi | (|ext_set[3:0]) | (|(lvl & ext_en));
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_req <= '0;
      irq_st <= 10'h000;
      irq <= 1'b0;
    end else begin
      irq_req <= '{chg: chg_flag & chg_en, ext: ext_en & (ext_flag | lvl)};
      irq_st <= irq_ev | (irq_st & ~((wr && wix == `PIO_IX_IRQ_CLR) ? {2'b11, w_data} : 10'h000));
      irq <= |(irq_st & irq_en);
    end
  end
  // a wake event ends sleep even if software writes the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      slp <= 2'b00;
      wake <= 1'b0;
    end else begin
      wake <= slp[`PIO_SLP_ON] & wake_ev;
      if (slp[`PIO_SLP_ON] && wake_ev) slp[`PIO_SLP_ON] <= 1'b0;
      else if (wr && wix == `PIO_IX_SLEEP) slp <= w_data[1:0];
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_pud; core_ctl[`PIO_PUD_BIT] |=> (pad_b.pull | pad_c.pull | pad_d.pull) == 8'h00; endproperty
  a_pud: assert property (p_pud) else $error("pull-up on while disabled");
  property p_lvl; ext_en[0] && lvl_mode[0] && !ext_in[0] |=> irq_req.ext[0]; endproperty
  a_lvl: assert property (p_lvl) else $error("level request missing");
  property p_lvflg; lvl_mode[1] |=> !ext_flag[1]; endproperty
  a_lvflg: assert property (p_lvflg) else $error("flag set in level mode");
  property p_grplo; grp_lo |=> chg_flag[0] ##1 (irq_req.chg[0] == chg_en[0] || !$stable(chg_en)); endproperty
  a_grplo: assert property (p_grplo) else $error("low group missed");
  property p_mask; $rose(chg_flag[0]) |-> $past(|(chg_diff[7:0] & msk_lo)); endproperty
  a_mask: assert property (p_mask) else $error("masked change fired");
  property p_grphi; grp_hi |=> chg_flag[1]; endproperty
  a_grphi: assert property (p_grphi) else $error("high group missed");
  property p_stop; slp[`PIO_SLP_ON] && !slp[`PIO_SLP_IDLE] |=> !io_run ##1 $stable(samp_now); endproperty
  a_stop: assert property (p_stop) else $error("i/o clock not stopped");
  property p_afall; sns_lo[1:0] == `PIO_SNS_FALL && ext_old[0] && !ext_in[0] |=> ext_flag[0]; endproperty
  a_afall: assert property (p_afall) else $error("async falling edge missed");
  property p_srise; sns_hi[1:0] == `PIO_SNS_RISE && io_tick && !samp_old[4] && samp_now[4] |=> ext_flag[4]; endproperty
  a_srise: assert property (p_srise) else $error("sampled rising edge missed");
  property p_ack; ext_flag[0] && ext_irq_ack[0] && !ext_set[0] |=> !ext_flag[0]; endproperty
  a_ack: assert property (p_ack) else $error("flag not cleared");
  property p_wake; slp[`PIO_SLP_ON] && !io_run && grp_lo |=> wake ##1 !slp[`PIO_SLP_ON]; endproperty
  a_wake: assert property (p_wake) else $error("no wake on change");
  cv_ext: cover property ($rose(ext_flag[0]));
  cv_wake: cover property (wake);
  cv_irq: cover property ($rose(irq));
  cv_wr: cover property (bvalid && bready);
endmodule

// *** design/pio_defines.svh ***
`ifndef PIO_DEFINES_SVH
`define PIO_DEFINES_SVH
// ****************************************
// register indices, byte address = 4 * index
// ****************************************
`define PIO_IX_PIN_B   8'h03
`define PIO_IX_DIR_B   8'h04
`define PIO_IX_LAT_B   8'h05
`define PIO_IX_PIN_C   8'h06
`define PIO_IX_DIR_C   8'h07
`define PIO_IX_LAT_C   8'h08
`define PIO_IX_PIN_D   8'h09
`define PIO_IX_DIR_D   8'h0a
`define PIO_IX_LAT_D   8'h0b
`define PIO_IX_CORE    8'h35
`define PIO_IX_SNS_LO  8'h40
`define PIO_IX_SNS_HI  8'h41
`define PIO_IX_EXT_EN  8'h42
`define PIO_IX_EXT_FLG 8'h43
`define PIO_IX_CHG_EN  8'h44
`define PIO_IX_CHG_FLG 8'h45
`define PIO_IX_MSK_LO  8'h46
`define PIO_IX_MSK_HI  8'h47
`define PIO_IX_SLEEP   8'h48
`define PIO_IX_IRQ_ST  8'h49
`define PIO_IX_IRQ_CLR 8'h4a
`define PIO_IX_IRQ_EN  8'h4b
// ****************************************
// fields and reset values
// ****************************************
`define PIO_PORT_C_OUTPUT_LATCH_MASK 8'hf7
`define PIO_CORE_MASK  8'h93
`define PIO_PUD_BIT    4
`define PIO_SLP_ON     0
`define PIO_SLP_IDLE   1
`define PIO_RST_BYTE   8'h00
`define PIO_SNS_LEVEL  2'b00
`define PIO_SNS_ANY    2'b01
`define PIO_SNS_FALL   2'b10
`define PIO_SNS_RISE   2'b11
`define PIO_RESP_OK    2'b00
`define PIO_RESP_ERR   2'b10
`endif

// *** design/pio_pkg.sv ***
package pio_pkg;
  // one port's pad controls, all registered
  typedef struct packed {
    logic [7:0] pull;
    logic [7:0] oe;
    logic [7:0] out;
  } pio_pad_t;
  // interrupt requests towards the core
  typedef struct packed {
    logic [1:0] chg;
    logic [7:0] ext;
  } pio_irq_t;
endpackage

// *** verification/pio_pin_src.sv ***
`timescale 1ns/1ps
// ****************************************
// far side: sources driving the port pads
// ****************************************
module pio_pin_src import pio_pkg::*; (
  input  wire logic  aclk,
  input  pio_pad_t   pad_b,
  input  pio_pad_t   pad_c,
  input  pio_pad_t   pad_d,
  output logic [7:0] pin_b,
  output logic [7:0] pin_c,
  output logic [7:0] pin_d
);
  logic [7:0] val [3] = '{8'hff, 8'hff, 8'hff};
  logic [7:0] en  [3] = '{8'hff, 8'hff, 8'hff};
  logic       tog     = 1'b0;

  // a released pin without pull-up moves every cycle, so it never passes for a clean level
  always @(posedge aclk) begin
    tog <= ~tog;
  end

  // a released pin follows the block's own driver when its direction bit is set
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_b[i] = en[0][i] ? val[0][i] : pad_b.oe[i] ? pad_b.out[i] : pad_b.pull[i] | tog;
      pin_c[i] = en[1][i] ? val[1][i] : pad_c.oe[i] ? pad_c.out[i] : pad_c.pull[i] | tog;
      pin_d[i] = en[2][i] ? val[2][i] : pad_d.oe[i] ? pad_d.out[i] : pad_d.pull[i] | tog;
    end
  end

  // a level stays until the caller changes it, so a wake level outlasts start-up
  task automatic put(input int p, input int b, input logic v, input logic e);
    val[p][b] <= v;
    en[p][b]  <= e;
  endtask
endmodule

// *** verification/pio_top_tb_top.sv ***
`timescale 1ns/1ps
`include "pio_defines.svh"
module pio_top_tb_top import pio_pkg::*;;
  logic        aclk    = 1'b0;
  logic        aresetn = 1'b0;
  logic [11:0] awaddr  = 12'h000;
  logic [11:0] araddr  = 12'h000;
  logic        awvalid = 1'b0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic [31:0] wdata   = 32'h00000000;
  logic [3:0]  wstrb   = 4'h0;
  logic [7:0]  ext_ack = 8'h00;
  logic [1:0]  chg_ack = 2'b00;
  wire         awready, wready, bvalid, arready, rvalid, irq, wake;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [7:0]  pin_b, pin_c, pin_d;
  pio_pad_t    pad_b, pad_c, pad_d;
  pio_irq_t    irq_req;
  int          err_total    = 0;
  int          total_checks = 0;
  int          wakes        = 0;

  pio_top #(.AW(12)) pio_top_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .pin_b_i(pin_b), .pin_c_i(pin_c), .pin_d_i(pin_d),
    .pad_b(pad_b), .pad_c(pad_c), .pad_d(pad_d), .ext_irq_ack(ext_ack), .change_irq_ack(chg_ack),
    .irq_req(irq_req), .irq(irq), .wake(wake));

  pio_pin_src pio_pin_src_i (.aclk(aclk), .pad_b(pad_b), .pad_c(pad_c), .pad_d(pad_d),
    .pin_b(pin_b), .pin_c(pin_c), .pin_d(pin_d));

  initial begin
    forever #12.5 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    if (wake === 1'b1) begin
      wakes <= wakes + 1;
    end
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // readies are registers, so the level at the falling edge is the one the next rising edge takes
  task automatic wr(input logic [7:0] ix, input logic [7:0] d, input logic [1:0] er);
    logic ta, tw, b; logic [1:0] r; int n;
    b = 1'b0; r = 2'b00; n = 0;
    awaddr <= {2'b00, ix, 2'b00};
    wdata <= {24'h000000, d};
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b && n < 100) begin
      @(negedge aclk);
      ta = awready & awvalid;
      tw = wready & wvalid;
      b = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      n++;
    end
    bready <= 1'b0;
    @(posedge aclk);
    chk("bvalid", 32'h1, {31'h0, b});
    chk("bresp", {30'h0, er}, {30'h0, r});
  endtask

  task automatic rd(input logic [7:0] ix, input logic [7:0] e, input logic [1:0] er);
    logic ta, b; logic [31:0] d; logic [1:0] r; int n;
    b = 1'b0; d = 32'h0; r = 2'b00; n = 0;
    araddr <= {2'b00, ix, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!b && n < 100) begin
      @(negedge aclk);
      ta = arready & arvalid;
      b = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      n++;
    end
    rready <= 1'b0;
    @(posedge aclk);
    chk("rvalid", 32'h1, {31'h0, b});
    chk("rdata", {24'h0, e}, d);
    chk("rresp", {30'h0, er}, {30'h0, r});
  endtask

  // port 0 = b, 1 = c, 2 = d; the wait covers synchroniser and two clocked samples
  task automatic pn(input int p, input int b, input logic v);
    pio_pin_src_i.put(p, b, v, 1'b1);
    cyc(12);
  endtask

  task automatic ack(input logic [7:0] e, input logic [1:0] c);
    ext_ack <= e;
    chg_ack <= c;
    @(posedge aclk);
    ext_ack <= 8'h00;
    chg_ack <= 2'b00;
    @(posedge aclk);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs();
    logic [7:0] ix [7] = '{`PIO_IX_DIR_B, `PIO_IX_LAT_B, `PIO_IX_DIR_C, `PIO_IX_LAT_C, `PIO_IX_DIR_D,
                           `PIO_IX_LAT_D, `PIO_IX_CORE};
    foreach (ix[i]) rd(ix[i], `PIO_RST_BYTE, `PIO_RESP_OK);
    rd(8'hff, 8'h00, `PIO_RESP_ERR);
    wr(8'hff, 8'h5a, `PIO_RESP_ERR);
    wr(`PIO_IX_DIR_C, 8'hff, `PIO_RESP_OK);
    chk("pad_c", 32'h00f700, pad_c);
    rd(`PIO_IX_DIR_C, `PIO_PORT_C_OUTPUT_LATCH_MASK, `PIO_RESP_OK);
    wr(`PIO_IX_DIR_C, 8'h00, `PIO_RESP_OK);
    wr(`PIO_IX_LAT_B, 8'hff, `PIO_RESP_OK);
    cyc(2);
    chk("pull_b", 32'hff, pad_b.pull);
    wr(`PIO_IX_CORE, 8'h10, `PIO_RESP_OK);
    cyc(2);
    chk("pull_b", 32'h00, pad_b.pull);
    rd(`PIO_IX_CORE, 8'h10, `PIO_RESP_OK);
    wr(`PIO_IX_CORE, 8'h00, `PIO_RESP_OK);
    wr(`PIO_IX_LAT_B, 8'h00, `PIO_RESP_OK);
  endtask

  task automatic t_sense();
    logic [7:0] fb; logic [1:0] m; int p, b;
    for (int k = 0; k < 2; k++) begin
      fb = k ? 8'h10 : 8'h01;
      p = k ? 1 : 2;
      b = k ? 7 : 0;
      for (int j = 1; j < 4; j++) begin
        m = j[1:0];
        wr(k ? `PIO_IX_SNS_HI : `PIO_IX_SNS_LO, {6'h00, m}, `PIO_RESP_OK);
        wr(`PIO_IX_EXT_FLG, 8'hff, `PIO_RESP_OK);
        pn(p, b, 1'b0);
        rd(`PIO_IX_EXT_FLG, (m != `PIO_SNS_RISE) ? fb : 8'h00, `PIO_RESP_OK);
        ack(fb, 2'b00);
        rd(`PIO_IX_EXT_FLG, 8'h00, `PIO_RESP_OK);
        pn(p, b, 1'b1);
        rd(`PIO_IX_EXT_FLG, (m != `PIO_SNS_FALL) ? fb : 8'h00, `PIO_RESP_OK);
        wr(`PIO_IX_EXT_FLG, fb, `PIO_RESP_OK);
        rd(`PIO_IX_EXT_FLG, 8'h00, `PIO_RESP_OK);
      end
    end
    wr(`PIO_IX_SNS_LO, {6'h00, `PIO_SNS_LEVEL}, `PIO_RESP_OK);
    wr(`PIO_IX_EXT_EN, 8'h01, `PIO_RESP_OK);
    pn(2, 0, 1'b0);
    rd(`PIO_IX_EXT_FLG, 8'h00, `PIO_RESP_OK);
    cyc(40);
    chk("ext_req_level", 32'h01, irq_req.ext);
    pn(2, 0, 1'b1);
    chk("ext_req_level", 32'h00, irq_req.ext);
  endtask

  task automatic t_out();
    wr(`PIO_IX_SNS_LO, 8'h0c, `PIO_RESP_OK);
    wr(`PIO_IX_DIR_D, 8'h02, `PIO_RESP_OK);
    pio_pin_src_i.put(2, 1, 1'b1, 1'b0);
    cyc(12);
    wr(`PIO_IX_EXT_FLG, 8'hff, `PIO_RESP_OK);
    wr(`PIO_IX_LAT_D, 8'h02, `PIO_RESP_OK);
    chk("pad_d", 32'h000202, pad_d);
    cyc(12);
    rd(`PIO_IX_EXT_FLG, 8'h02, `PIO_RESP_OK);
    pio_pin_src_i.put(2, 1, 1'b1, 1'b1);
    wr(`PIO_IX_DIR_D, 8'h00, `PIO_RESP_OK);
    wr(`PIO_IX_LAT_D, 8'h00, `PIO_RESP_OK);
  endtask

  task automatic t_chg();
    wr(`PIO_IX_CHG_EN, 8'h03, `PIO_RESP_OK);
    wr(`PIO_IX_MSK_LO, 8'h02, `PIO_RESP_OK);
    wr(`PIO_IX_MSK_HI, 8'h01, `PIO_RESP_OK);
    wr(`PIO_IX_CHG_FLG, 8'h03, `PIO_RESP_OK);
    pn(0, 0, 1'b0);
    rd(`PIO_IX_CHG_FLG, 8'h00, `PIO_RESP_OK);
    pn(0, 1, 1'b0);
    rd(`PIO_IX_CHG_FLG, 8'h01, `PIO_RESP_OK);
    chk("chg_req", 32'h1, irq_req.chg);
    ack(8'h00, 2'b01);
    rd(`PIO_IX_CHG_FLG, 8'h00, `PIO_RESP_OK);
    pn(1, 4, 1'b0);
    rd(`PIO_IX_CHG_FLG, 8'h02, `PIO_RESP_OK);
    chk("chg_req", 32'h2, irq_req.chg);
    wr(`PIO_IX_CHG_FLG, 8'h02, `PIO_RESP_OK);
  endtask

  task automatic t_sleep();
    int w0;
    wr(`PIO_IX_SNS_LO, 8'h03, `PIO_RESP_OK);
    pn(2, 0, 1'b0);
    pn(1, 7, 1'b0);
    wr(`PIO_IX_EXT_FLG, 8'hff, `PIO_RESP_OK);
    wr(`PIO_IX_EXT_EN, 8'h11, `PIO_RESP_OK);
    w0 = wakes;
    wr(`PIO_IX_SLEEP, 8'h01, `PIO_RESP_OK);
    pn(1, 7, 1'b1);
    chk("ext_req_sleep", 32'h00, irq_req.ext);
    chk("wakes", w0, wakes);
    pn(2, 0, 1'b1);
    chk("ext_req_sleep", 32'h01, irq_req.ext[0]);
    chk("wakes", w0 + 1, wakes);
    rd(`PIO_IX_SLEEP, 8'h00, `PIO_RESP_OK);
    wr(`PIO_IX_SLEEP, 8'h01, `PIO_RESP_OK);
    pn(0, 1, 1'b1);
    chk("wakes", w0 + 2, wakes);
    rd(`PIO_IX_CHG_FLG, 8'h01, `PIO_RESP_OK);
    wr(`PIO_IX_EXT_FLG, 8'hff, `PIO_RESP_OK);
    wr(`PIO_IX_SLEEP, 8'h03, `PIO_RESP_OK);
    pn(1, 7, 1'b0);
    pn(1, 7, 1'b1);
    chk("ext_req_idle", 32'h10, irq_req.ext);
    wr(`PIO_IX_SLEEP, 8'h00, `PIO_RESP_OK);
    wr(`PIO_IX_EXT_EN, 8'h00, `PIO_RESP_OK);
  endtask

  task automatic t_irq();
    wr(`PIO_IX_SNS_LO, 8'h01, `PIO_RESP_OK);
    wr(`PIO_IX_IRQ_EN, 8'h01, `PIO_RESP_OK);
    wr(`PIO_IX_IRQ_CLR, 8'hff, `PIO_RESP_OK);
    rd(`PIO_IX_IRQ_ST, 8'h00, `PIO_RESP_OK);
    chk("irq", 32'h0, irq);
    pn(2, 0, 1'b0);
    rd(`PIO_IX_IRQ_ST, 8'h01, `PIO_RESP_OK);
    chk("irq", 32'h1, irq);
    wr(`PIO_IX_IRQ_EN, 8'h00, `PIO_RESP_OK);
    cyc(2);
    chk("irq", 32'h0, irq);
    wr(`PIO_IX_IRQ_EN, 8'h01, `PIO_RESP_OK);
    cyc(2);
    chk("irq", 32'h1, irq);
    wr(`PIO_IX_IRQ_CLR, 8'h01, `PIO_RESP_OK);
    cyc(2);
    rd(`PIO_IX_IRQ_ST, 8'h00, `PIO_RESP_OK);
    chk("irq", 32'h0, irq);
  endtask

  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    cyc(10);
    t_regs();
    wr(`PIO_IX_EXT_FLG, 8'hff, `PIO_RESP_OK);
    wr(`PIO_IX_CHG_FLG, 8'h03, `PIO_RESP_OK);
    t_sense();
    t_out();
    t_chg();
    t_sleep();
    t_irq();
    end_sim();
  end

  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    end_sim();
  end
endmodule
